// *** hw/framer_pkg.sv ***
// Constants, field layouts and types shared by the slot framer files.
// Assumes one symbol clock and signed 16-bit I/Q samples.
package framer_pkg;

  localparam int SYM_W = 16;
  localparam int POS_W = 12;
  localparam int CU_W = 10;
  localparam int LFSR_W = 18;
  localparam int BUF_W = 2 * SYM_W + 3;

  // Slot layout in symbol periods
  localparam logic [POS_W-1:0] SLOT_LAST = 12'h87F;
  localparam logic [POS_W-1:0] PILOT_LEN = 12'h050;
  localparam logic [POS_W-1:0] PILOT2_START = 12'h440;
  localparam logic [POS_W-1:0] DATA2_START = 12'h490;

  // One over root two in Q1.14
  localparam logic [SYM_W-1:0] PILOT_AMP = 16'h2D41;

  // Last symbol index in a capacity unit, and last unit index in a slot
  localparam logic [CU_W-1:0] CU_LAST_QPSK = 10'h3EF;
  localparam logic [CU_W-1:0] CU_LAST_8PSK = 10'h29F;
  localparam logic [CU_W-1:0] CU_LAST_16APSK = 10'h1F7;
  localparam logic [1:0] CU_IDX_LAST_QPSK = 2'h1;
  localparam logic [1:0] CU_IDX_LAST_8PSK = 2'h2;
  localparam logic [1:0] CU_IDX_LAST_16APSK = 2'h3;

  // Gold generator
  localparam logic [LFSR_W-1:0] X_INIT = 18'h00001;
  localparam logic [LFSR_W-1:0] Y_INIT = 18'h3FFFF;
  localparam int X_TAP = 7;
  localparam int Y_TAP_A = 5;
  localparam int Y_TAP_B = 7;
  localparam int Y_TAP_C = 10;
  localparam logic [LFSR_W-1:0] X_AHEAD_MASK = 18'h08050;
  localparam logic [LFSR_W-1:0] Y_AHEAD_MASK = 18'h0FF60;

  // Register map, byte addresses
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] CTRL_ADR = 8'h00;
  localparam logic [ADR_W-1:0] STATUS_ADR = 8'h04;
  localparam logic [ADR_W-1:0] SLOTS_ADR = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MOD_LSB = 1;
  localparam int CTRL_MOD_MSB = 2;

  typedef enum logic [1:0] {MOD_QPSK, MOD_8PSK, MOD_16APSK} modulation_t;

endpackage

// *** hw/gold_chip_gen.sv ***
// Gold-code rotation generator for the slot scrambler.
// Assumes the caller steps it once per emitted symbol.
`timescale 1ns/100ps
module gold_chip_gen
  import framer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic step_i,
  output logic [1:0] rot_o
);

  typedef struct packed {
    logic [LFSR_W-1:0] x;
    logic [LFSR_W-1:0] y;
  } gen_state_t;

  gen_state_t st_r;
  gen_state_t st_nxt;
  logic gold_now;
  logic gold_ahead;

  always_comb begin
    st_nxt = st_r;
    if (restart_i) begin
      st_nxt.x = X_INIT;
      st_nxt.y = Y_INIT;
    end else if (step_i) begin
      st_nxt.x = {st_r.x[0] ^ st_r.x[X_TAP], st_r.x[LFSR_W-1:1]};
      st_nxt.y = {st_r.y[0] ^ st_r.y[Y_TAP_A] ^ st_r.y[Y_TAP_B] ^ st_r.y[Y_TAP_C], st_r.y[LFSR_W-1:1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{x: X_INIT, y: Y_INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Fixed tap masks jump both registers far ahead without a second pair
  assign gold_now = st_r.x[0] ^ st_r.y[0];
  assign gold_ahead = (^(st_r.x & X_AHEAD_MASK)) ^ (^(st_r.y & Y_AHEAD_MASK));
  assign rot_o = {gold_ahead, gold_now};

  a_gold_init: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(restart_i) |-> (rot_o == 2'h0 && st_r.x == X_INIT))
    else $error("Generator not at initial state after restart");
  a_gold_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!step_i && !restart_i) |=> $stable(st_r))
    else $error("Generator moved without a step");

endmodule

// *** hw/pair_buffer.sv ***
// Two-entry valid/ready buffer for the output stream.
// Assumes the sink may stall for any time; no word is dropped.
`timescale 1ns/100ps
module pair_buffer #(
  parameter int W = 35
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } buf_state_t;

  buf_state_t st_r;
  buf_state_t st_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (st_r.cnt != 2'h2);
  assign out_valid_o = (st_r.cnt != 2'h0);
  assign out_data_o = st_r.mem[st_r.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data_i;
      st_nxt.wp = ~st_r.wp;
    end
    if (pop) begin
      st_nxt.rp = ~st_r.rp;
    end
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_buf_full: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.cnt == 2'h2 && !out_ready_i) |=> (st_r.cnt == 2'h2 && !in_ready_o))
    else $error("Full buffer accepted a word");

endmodule

// *** hw/slot_framer.sv ***
// Slot framer: pilot insertion, capacity unit placement and scrambling.
// Assumes a mapper feeding signed I/Q symbols, a shaping filter draining
// the output, clk_i running at the symbol rate, and a Wishbone master.
//
// Functional notes
// - Slots repeat back to back, each exactly 2176 symbol periods long.
// - A slot holds two to four capacity units of 2016 bits each.
// - Units per slot: QPSK two, 8PSK three, 16APSK four.
// - Two pilot fields per slot, each 80 symbols long.
// - Pilot symbols are unmodulated, I and Q both one over root two.
// - Order is pilot, 1008-symbol sub-slot, pilot, 1008-symbol sub-slot.
// - Every symbol, pilots too, is rotated by its complex chip before output.
// - Chip generator restarts at each slot's first symbol.
// - First register follows 1 + x^7 + x^18.
// - Second register follows taps at orders 5, 7, 10 and 18.
// - Restart loads first register with one at bit zero, second all ones.
// - Gold bit is the XOR of both sequence outputs.
// - Rotation index is twice the Gold bit 131072 ahead plus current bit.
// - Chip is a rotation by index times ninety degrees.
// - Index 0 gives (I,Q), 1 (-Q,I), 2 (-I,-Q), 3 (Q,-I).
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module slot_framer
  import framer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mapped symbols in
  input wire logic sym_valid_i,
  output logic sym_ready_o,
  input wire logic [SYM_W-1:0] sym_i_i,
  input wire logic [SYM_W-1:0] sym_q_i,
  // Scrambled slot stream out
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [SYM_W-1:0] out_i_o,
  output logic [SYM_W-1:0] out_q_o,
  output logic out_slot_first_o,
  output logic out_pilot_o,
  output logic out_cu_first_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [POS_W-1:0] pos;
    logic [CU_W-1:0] cu_sym;
    logic [1:0] cu_idx;
    modulation_t mode;
    logic enable;
    modulation_t mode_cfg;
    logic [15:0] slots;
    logic ack;
    logic [31:0] rdata;
  } framer_state_t;

  framer_state_t st_r;
  framer_state_t st_nxt;

  logic pilot;
  logic slot_last;
  logic cu_last;
  logic [CU_W-1:0] cu_len_last;
  logic [1:0] cu_idx_last;
  logic [SYM_W-1:0] src_i;
  logic [SYM_W-1:0] src_q;
  logic [SYM_W-1:0] scr_i;
  logic [SYM_W-1:0] scr_q;
  logic [1:0] rot;
  logic buf_ready;
  logic adv;
  logic gen_restart;
  logic wb_req;
  logic ctrl_wr;
  logic slots_clr;
  logic [BUF_W-1:0] buf_in;
  logic [BUF_W-1:0] buf_out;

  ////////////////////////////////////////////////////////////////////////////
  // Slot position decode

  // Pilot ahead of each sub-slot
  assign pilot = (st_r.pos < PILOT_LEN) ||
                 (st_r.pos >= PILOT2_START && st_r.pos < DATA2_START);
  assign slot_last = (st_r.pos == SLOT_LAST);

  always_comb begin
    unique case (st_r.mode)
      MOD_QPSK: begin
        cu_len_last = CU_LAST_QPSK;
        cu_idx_last = CU_IDX_LAST_QPSK;
      end
      MOD_8PSK: begin
        cu_len_last = CU_LAST_8PSK;
        cu_idx_last = CU_IDX_LAST_8PSK;
      end
      MOD_16APSK: begin
        cu_len_last = CU_LAST_16APSK;
        cu_idx_last = CU_IDX_LAST_16APSK;
      end
      default: begin
        cu_len_last = CU_LAST_QPSK;
        cu_idx_last = CU_IDX_LAST_QPSK;
      end
    endcase
  end

  assign cu_last = (st_r.cu_sym == cu_len_last);

  ////////////////////////////////////////////////////////////////////////////
  // Source select and scrambling

  // Mapper output taken as is; bit order is settled upstream
  assign src_i = pilot ? PILOT_AMP : sym_i_i;
  assign src_q = pilot ? PILOT_AMP : sym_q_i;

  // Full-scale negative input wraps on negation; keep mapper below it
  always_comb begin
    unique case (rot)
      2'h0: begin
        scr_i = src_i;
        scr_q = src_q;
      end
      2'h1: begin
        scr_i = -src_q;
        scr_q = src_i;
      end
      2'h2: begin
        scr_i = -src_i;
        scr_q = -src_q;
      end
      2'h3: begin
        scr_i = src_q;
        scr_q = -src_i;
      end
    endcase
  end

  // Pilots need no input, so they never wait on the mapper
  assign adv = st_r.enable && buf_ready && (pilot || sym_valid_i);
  assign sym_ready_o = st_r.enable && buf_ready && !pilot;
  assign gen_restart = !st_r.enable || (adv && slot_last);

  gold_chip_gen u_gold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(gen_restart),
    .step_i(adv),
    .rot_o(rot)
  );

  assign buf_in = {scr_i, scr_q, (st_r.pos == '0), pilot,
                   (!pilot && st_r.cu_sym == '0)};

  pair_buffer #(
    .W(BUF_W)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(adv),
    .in_ready_o(buf_ready),
    .in_data_i(buf_in),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(buf_out)
  );

  assign out_i_o = buf_out[BUF_W-1 -: SYM_W];
  assign out_q_o = buf_out[SYM_W+2 -: SYM_W];
  assign out_slot_first_o = buf_out[2];
  assign out_pilot_o = buf_out[1];
  assign out_cu_first_o = buf_out[0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign wb_req = wb_cyc_i && wb_stb_i && !st_r.ack;
  // Only byte lane 0 carries writable bits
  assign ctrl_wr = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == CTRL_ADR);
  assign slots_clr = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == SLOTS_ADR);

  always_comb begin
    st_nxt = st_r;
    if (!st_r.enable) begin
      st_nxt.pos = '0;
      st_nxt.cu_sym = '0;
      st_nxt.cu_idx = '0;
      st_nxt.mode = st_r.mode_cfg;
    end else if (adv) begin
      if (slot_last) begin
        st_nxt.pos = '0;
        st_nxt.cu_sym = '0;
        st_nxt.cu_idx = '0;
        // Mode changes only between slots
        st_nxt.mode = st_r.mode_cfg;
        st_nxt.slots = st_r.slots + 16'h0001;
      end else begin
        st_nxt.pos = st_r.pos + 12'h001;
      end
      if (!pilot && !slot_last) begin
        if (cu_last) begin
          st_nxt.cu_sym = '0;
          st_nxt.cu_idx = (st_r.cu_idx == cu_idx_last) ? 2'h0 : st_r.cu_idx + 2'h1;
        end else begin
          st_nxt.cu_sym = st_r.cu_sym + 10'h001;
        end
      end
    end
    // Wishbone: one wait state, ack drops the cycle after it rose
    st_nxt.ack = wb_req;
    st_nxt.rdata = '0;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        CTRL_ADR: st_nxt.rdata = {29'h0, st_r.mode_cfg, st_r.enable};
        STATUS_ADR: st_nxt.rdata = {16'h0, st_r.cu_idx, st_r.mode, st_r.pos};
        SLOTS_ADR: st_nxt.rdata = {16'h0, st_r.slots};
        default: st_nxt.rdata = '0;
      endcase
    end
    if (ctrl_wr) begin
      st_nxt.enable = wb_dat_i[CTRL_EN_BIT];
      st_nxt.mode_cfg = (wb_dat_i[CTRL_MOD_MSB:CTRL_MOD_LSB] == 2'h3) ? MOD_QPSK
                        : modulation_t'(wb_dat_i[CTRL_MOD_MSB:CTRL_MOD_LSB]);
    end
    if (slots_clr) begin
      // Completion in the same cycle as a clear still counts
      st_nxt.slots = (adv && slot_last) ? 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{default: '0, mode: MOD_QPSK, mode_cfg: MOD_QPSK};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_slot_wrap: assert property ((adv && slot_last) |=> (st_r.pos == '0))
    else $error("Slot did not wrap after its last symbol");
  a_pilot_no_take: assert property (pilot |-> !sym_ready_o)
    else $error("Input taken during a pilot field");
  a_pilot_second: assert property ((adv && st_r.pos == PILOT2_START - 12'h001) |=> pilot)
    else $error("Second pilot field missing after first sub-slot");
  a_pilot_value: assert property ((adv && pilot && rot == 2'h2) |-> (buf_in[BUF_W-1 -: SYM_W] == -PILOT_AMP))
    else $error("Pilot symbol not scrambled from unit amplitude");
  a_rot_quarter: assert property ((adv && !pilot && rot == 2'h1) |-> (buf_in[SYM_W+2 -: SYM_W] == sym_i_i))
    else $error("Quarter rotation put wrong value on Q");
  a_gen_slot: assert property ((adv && slot_last) |=> (rot == 2'h0))
    else $error("Chip sequence did not restart at slot start");
  a_cu_wrap: assert property ((adv && !pilot && !slot_last && cu_last) |=> (st_r.cu_sym == '0))
    else $error("Capacity unit length wrong");
  a_wb_ack: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not one cycle after request");

  // Slot layout and unit placement
  a_pos_range: assert property (st_r.pos <= SLOT_LAST)
    else $error("Slot position beyond last symbol");
  a_idle_pos: assert property (!st_r.enable |=> (st_r.pos == '0))
    else $error("Slot position kept while disabled");
  a_first_pilot: assert property ((adv && st_r.pos == '0) |-> pilot)
    else $error("Slot does not open with a pilot");
  a_sub1_start: assert property ((adv && st_r.pos == PILOT_LEN - 12'h001) |=> !pilot)
    else $error("First pilot field has wrong length");
  a_sub2_start: assert property ((adv && st_r.pos == DATA2_START - 12'h001) |=> !pilot)
    else $error("Second pilot field has wrong length");
  a_slot_units: assert property ((adv && slot_last) |-> (cu_last && st_r.cu_idx == cu_idx_last))
    else $error("Capacity units do not fill the slot");
  a_cu_start: assert property ((adv && st_r.pos == PILOT_LEN) |-> (st_r.cu_sym == '0 && st_r.cu_idx == '0))
    else $error("First unit not aligned to first data symbol");
  a_pilot_idx: assert property ((adv && pilot) |=> $stable(st_r.cu_sym))
    else $error("Pilot symbol counted as payload");
  a_mode_hold: assert property ((st_r.enable && !(adv && slot_last)) |=> $stable(st_r.mode))
    else $error("Modulation changed inside a slot");
  a_slot_count: assert property ((adv && slot_last && !wb_req) |=>
    (st_r.slots == $past(st_r.slots) + 16'h0001))
    else $error("Completed slot not counted");

  // Stalls hold everything still
  a_stall_pos: assert property ((st_r.enable && !adv) |=> $stable(st_r.pos))
    else $error("Slot position moved without an emitted symbol");
  a_stall_cu: assert property ((st_r.enable && !adv) |=> $stable(st_r.cu_sym))
    else $error("Unit counter moved without an emitted symbol");
  a_gen_still: assert property ((st_r.enable && !adv) |=> $stable(rot))
    else $error("Chip moved without an emitted symbol");
  a_pilot_no_wait: assert property ((st_r.enable && buf_ready && pilot) |-> adv)
    else $error("Pilot held back by the mapper");
  a_restart_idle: assert property (!st_r.enable |=> (rot == 2'h0))
    else $error("Chip sequence not restarted while disabled");

  // Rotation of payload and pilots
  a_rot_zero: assert property ((adv && !pilot && rot == 2'h0) |->
    (buf_in[BUF_W-1 -: SYM_W] == sym_i_i && buf_in[SYM_W+2 -: SYM_W] == sym_q_i))
    else $error("Zero rotation altered the symbol");
  a_rot_quarter_i: assert property ((adv && !pilot && rot == 2'h1) |->
    (buf_in[BUF_W-1 -: SYM_W] == -sym_q_i))
    else $error("Quarter rotation put wrong value on I");
  a_rot_half: assert property ((adv && !pilot && rot == 2'h2) |->
    (buf_in[SYM_W+2 -: SYM_W] == -sym_q_i))
    else $error("Half rotation put wrong value on Q");
  a_rot_three: assert property ((adv && !pilot && rot == 2'h3) |->
    (buf_in[BUF_W-1 -: SYM_W] == sym_q_i))
    else $error("Three-quarter rotation put wrong value on I");
  a_pilot_plain: assert property ((adv && pilot && rot == 2'h0) |->
    (buf_in[BUF_W-1 -: SYM_W] == PILOT_AMP && buf_in[SYM_W+2 -: SYM_W] == PILOT_AMP))
    else $error("Unrotated pilot not at unit amplitude");

  // Register bus
  a_wb_quiet: assert property (!wb_ack_o |-> (wb_dat_o == '0))
    else $error("Read data present without ack");
  a_wb_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack held longer than one cycle");
  a_enable_on: assert property ((ctrl_wr && wb_dat_i[CTRL_EN_BIT]) |=> st_r.enable)
    else $error("Enable write not taken");
  a_slots_clear: assert property ((slots_clr && !(adv && slot_last)) |=> (st_r.slots == '0))
    else $error("Slot count not cleared");
  a_slots_set: assert property ((slots_clr && adv && slot_last) |=> (st_r.slots == 16'h0001))
    else $error("Slot completion lost to a clear");

  c_slot_done: cover property (adv && slot_last);
  c_mode_8: cover property (adv && st_r.mode == MOD_8PSK && slot_last);
  c_pilot_out: cover property (out_valid_o && out_ready_i && out_pilot_o);
  c_stall: cover property (out_valid_o && !out_ready_i ##1 !buf_ready);
  c_mode_16: cover property (adv && st_r.mode == MOD_16APSK && cu_last && st_r.cu_idx == cu_idx_last);

endmodule

// *** bench/shaping_sink.sv ***
// Stand-in for the shaping filter that drains the framer output.
// Assumes one clock; ready moves only just after a rising edge.
`timescale 1ns/100ps
module shaping_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] stall_mode_i,
  output logic ready_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Mode 0 prompt, 1 slow, 2 half rate, 3 held off so the buffer fills
  always @(posedge clk_i) begin
    if (rst_i || stall_mode_i == 2'h0) begin
      ready_o <= 1'b1;
    end else if (stall_mode_i == 2'h3) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= ($urandom_range(0, 3) < 32'(stall_mode_i));
    end
  end
endmodule

// *** bench/tdm_slot_framer_scrambler_bench.sv ***
// Self-checking bench for the slot framer: three slots, one per modulation.
// Assumes the framer package, a 25 MHz symbol clock and the sink model.
`timescale 1ns/100ps
module tdm_slot_framer_scrambler_bench
  import framer_pkg::*;
;
  localparam int AHEAD = 131072;
  logic clk_i;
  logic rst_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic sym_valid_i;
  logic sym_ready_o;
  logic out_valid_o;
  logic out_ready_i;
  logic out_slot_first_o;
  logic out_pilot_o;
  logic out_cu_first_o;
  logic [SYM_W-1:0] sym_i_i;
  logic [SYM_W-1:0] sym_q_i;
  logic [SYM_W-1:0] out_i_o;
  logic [SYM_W-1:0] out_q_o;
  logic [1:0] stall_mode;
  logic [34:0] exp_q[$];
  bit zb [0:AHEAD+2175];
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int drv_slot = 0;
  int drv_pos = 0;

  slot_framer u_slot_framer (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .sym_valid_i, .sym_ready_o, .sym_i_i, .sym_q_i, .out_valid_o,
    .out_ready_i, .out_i_o, .out_q_o, .out_slot_first_o, .out_pilot_o, .out_cu_first_o);
  shaping_sink u_shaping_sink (.clk_i, .rst_i, .stall_mode_i(stall_mode), .ready_o(out_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(string name, logic [34:0] e, logic [34:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wb_xfer(logic we, logic [ADR_W-1:0] adr, logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Expected word for slot position p: chip rotation plus side flags
  function automatic logic [34:0] expect_word(int p, int bits, logic [15:0] i, logic [15:0] q);
    logic [1:0] r;
    logic [31:0] s;
    logic pl;
    int d;
    r = {zb[p+AHEAD], zb[p]};
    pl = (p < 80) || (p >= 1088 && p < 1168);
    d = (p < 1088) ? p - 80 : p - 160;
    case (r)
      2'h0: s = {i, q};
      2'h1: s = {16'h0 - q, i};
      2'h2: s = {16'h0 - i, 16'h0 - q};
      default: s = {q, 16'h0 - i};
    endcase
    return {s, p == 0, pl, !pl && (d % (2016 / bits) == 0)};
  endfunction

  task automatic run_slot(int k, int bits);
    logic [15:0] iv;
    logic [15:0] qv;
    for (int p = 0; p < 2176; p++) begin
      drv_slot = k;
      drv_pos = p;
      if (p < 80 || (p >= 1088 && p < 1168)) begin
        exp_q.push_back(expect_word(p, bits, PILOT_AMP, PILOT_AMP));
      end else begin
        // Full-scale negative avoided: its negation wraps
        iv = 16'($urandom);
        qv = 16'($urandom);
        if (iv == 16'h8000) iv = 16'h0000;
        if (qv == 16'h8000) qv = 16'h0000;
        exp_q.push_back(expect_word(p, bits, iv, qv));
        sym_valid_i <= 1'b1;
        sym_i_i <= iv;
        sym_q_i <= qv;
        @(posedge clk_i);
        while (sym_ready_o !== 1'b1) @(posedge clk_i);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (rst_i === 1'b0 && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      if (exp_q.size() == 0) check("extra word", 35'h0, 35'h1);
      else check("word", exp_q.pop_front(), {out_i_o, out_q_o, out_slot_first_o, out_pilot_o, out_cu_first_o});
    end
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    bit xs [0:AHEAD+2175];
    bit ys [0:AHEAD+2175];
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    sym_valid_i = 1'b0;
    sym_i_i = '0;
    sym_q_i = '0;
    // Sink held off until the first pilots are queued as expected words
    stall_mode = 2'h3;
    rst_i = 1'b1;
    for (int n = 0; n <= AHEAD + 2175; n++) begin
      xs[n] = (n < 18) ? (n == 0) : xs[n-11] ^ xs[n-18];
      ys[n] = (n < 18) ? 1'b1 : ys[n-8] ^ ys[n-11] ^ ys[n-13] ^ ys[n-18];
      zb[n] = xs[n] ^ ys[n];
    end
    void'($urandom(32'h087F));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_xfer(1'b1, CTRL_ADR, 32'h1, rd);
    wb_xfer(1'b0, CTRL_ADR, 32'h0, rd);
    check("ctrl", 35'h1, 35'(rd));
    wb_xfer(1'b0, 8'h10, 32'h0, rd);
    check("unmapped", 35'h0, 35'(rd));
    fork
      begin
        for (int k = 0; k < 3; k++) run_slot(k, k + 2);
        for (int p = 0; p < 80; p++) exp_q.push_back(expect_word(p, 4, PILOT_AMP, PILOT_AMP));
        sym_valid_i <= 1'b0;
      end
      begin
        stall_mode <= 2'h0;
        // Mode written mid-slot; taken at the next boundary
        for (int k = 1; k < 3; k++) begin
          wait (drv_slot == k - 1 && drv_pos >= 1200);
          stall_mode <= 2'(k);
          wb_xfer(1'b1, CTRL_ADR, 32'(k * 2 + 1), rd);
        end
        stall_mode <= 2'h3;
        repeat (10) @(posedge clk_i);
        check("buffer full", 35'h1, {34'h0, sym_ready_o === 1'b0 && out_valid_o === 1'b1});
        stall_mode <= 2'h2;
      end
    join
    while (exp_q.size() != 0) @(posedge clk_i);
    repeat (6) @(posedge clk_i);
    wb_xfer(1'b0, SLOTS_ADR, 32'h0, rd);
    check("slots", 35'h3, 35'(rd[15:0]));
    wb_xfer(1'b0, STATUS_ADR, 32'h0, rd);
    check("mode", 35'(MOD_16APSK), 35'(rd[13:12]));
    check("pos", 35'(PILOT_LEN), 35'(rd[11:0]));
    wb_xfer(1'b1, SLOTS_ADR, 32'h0, rd);
    wb_xfer(1'b0, SLOTS_ADR, 32'h0, rd);
    check("slots clear", 35'h0, 35'(rd));
    // Mode code 3 falls back to QPSK
    wb_xfer(1'b1, CTRL_ADR, 32'h7, rd);
    wb_xfer(1'b0, CTRL_ADR, 32'h0, rd);
    check("ctrl mode 3", 35'h1, 35'(rd));
    end_sim();
  end
endmodule
